//--- logic/pnvm_map.svh
`ifndef PNVM_MAP_SVH
`define PNVM_MAP_SVH

// ==========================================================================
// Register indices and byte addresses
`define PNVM_IDX_SELECT      8'h0E
`define PNVM_IDX_STATUS      8'h0F
`define PNVM_ADDR_SELECT     ({22'h000000, `PNVM_IDX_SELECT, 2'b00})
`define PNVM_ADDR_STATUS     ({22'h000000, `PNVM_IDX_STATUS, 2'b00})

// ==========================================================================
// Status/control field positions
`define PNVM_SC_CZF          0
`define PNVM_SC_FULL         2
`define PNVM_SC_PGM          3
`define PNVM_SC_ROW          4
`define PNVM_SC_PEN          5
`define PNVM_SC_PCLK         6
`define PNVM_SC_DATA         7

// ==========================================================================
// Reset values
`define PNVM_SEL_RST         8'h00
`define PNVM_CTRL_RST        5'h00

// ==========================================================================
// Timing
`define PNVM_CLK_PERIOD_NS   50
`define PNVM_PUMP_STARTUP_NS 100000
`define PNVM_PGM_PULSE_NS    1000000
`define PNVM_PUMP_STARTUP_CYC \
    ((`PNVM_PUMP_STARTUP_NS + `PNVM_CLK_PERIOD_NS - 1) / `PNVM_CLK_PERIOD_NS)
`define PNVM_PGM_PULSE_CYC \
    ((`PNVM_PGM_PULSE_NS + `PNVM_CLK_PERIOD_NS - 1) / `PNVM_CLK_PERIOD_NS)
`define PNVM_CNT_W           16

`endif

//--- logic/pnvm_pkg.sv
package pnvm_pkg;

    // ======================================================================
    // Bus transfer types
    typedef enum logic [1:0] {
        TR_IDLE   = 2'b00,
        TR_BUSY   = 2'b01,
        TR_NONSEQ = 2'b10,
        TR_SEQ    = 2'b11
    } pnvm_trans_t;

    // ======================================================================
    // Control bits held by software
    typedef struct packed {
        logic pump_clock_select;
        logic pump_enable;
        logic row_erase;
        logic bit_program;
        logic full_erase;
    } pnvm_ctrl_t;

    // ======================================================================
    // Array operations
    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_PROG = 2'b01,
        CMD_ROW  = 2'b10,
        CMD_FULL = 2'b11
    } pnvm_cmd_t;

    // ======================================================================
    // Charge pump states
    typedef enum logic [1:0] {
        PUMP_OFF   = 2'b00,
        PUMP_START = 2'b01,
        PUMP_ON    = 2'b10
    } pnvm_pump_st_t;

endpackage

//--- logic/pnvm_pump.sv
`timescale 1ns/1ps
`include "pnvm_map.svh"

module pnvm_pump #(
    parameter logic [`PNVM_CNT_W-1:0] START_CYC = 16'd2000
) (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire pnvm_pkg::pnvm_ctrl_t ctrl,
    output logic                    pump_running,
    output logic                    pump_ready
);
    import pnvm_pkg::*;

    pnvm_pump_st_t           state_ff;
    logic [`PNVM_CNT_W-1:0]  cnt_ff;
    logic                    op_any;
    logic                    start_req;

    assign op_any    = ctrl.row_erase | ctrl.bit_program | ctrl.full_erase;
    assign start_req = ctrl.pump_enable & op_any;

    // ======================================================================
    // Startup sequencing
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= PUMP_OFF;
            cnt_ff   <= '0;
        end else begin
            case (state_ff)
                PUMP_OFF: begin
                    cnt_ff <= '0;
                    if (start_req) begin
                        state_ff <= PUMP_START; // RQ10
                    end
                end
                PUMP_START: begin
                    if (!start_req) begin
                        state_ff <= PUMP_OFF;
                    end else if (cnt_ff == START_CYC - 16'd1) begin
                        state_ff <= PUMP_ON; // RQ22
                    end else begin
                        cnt_ff <= cnt_ff + 16'd1;
                    end
                end
                PUMP_ON: begin
                    // Dropping only the enable does not stop a running pump
                    if (!op_any) begin
                        state_ff <= PUMP_OFF; // RQ10
                    end
                end
                default: state_ff <= PUMP_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pump_running <= 1'b0;
        end else begin
            // During startup the enable still counts; only a ready pump ignores it
            pump_running <= (state_ff == PUMP_ON) ? op_any : start_req;
        end
    end

    assign pump_ready = (state_ff == PUMP_ON);

endmodule // pnvm_pump

//--- logic/pnvm_array.sv
`timescale 1ns/1ps

module pnvm_array (
    input  wire logic                core_clk,
    input  wire logic [6:0]          sel,
    input  wire logic [6:0]          sense_sel,
    input  wire pnvm_pkg::pnvm_cmd_t cmd,
    input  wire logic                wr_en,
    output logic                     sense_bit
);
    import pnvm_pkg::*;

    logic [15:0]  row_hot;
    logic [7:0]   col_hot;
    logic [127:0] cells_w;

    // ======================================================================
    // Row and column decoders
    always_comb begin
        row_hot = '0;
        col_hot = '0;
        row_hot[sel[6:3]] = 1'b1; // RQ2
        col_hot[sel[2:0]] = 1'b1; // RQ3
    end

    // ======================================================================
    // Cells, 16 rows by 8 columns; reset never touches them
    for (genvar i = 0; i < 128; i++) begin : g_cell
        logic cell_q = 1'b0;
        always_ff @(posedge core_clk) begin
            if (wr_en) begin
                if (cmd == CMD_FULL) begin
                    cell_q <= 1'b0; // RQ17
                end else if (cmd == CMD_ROW && row_hot[i/8]) begin
                    cell_q <= 1'b0; // RQ12
                end else if (cmd == CMD_PROG && row_hot[i/8] && col_hot[i%8]) begin
                    cell_q <= 1'b1; // RQ15
                end
            end
        end
        assign cells_w[i] = cell_q; // RQ1
    end

    // Single shared sense amplifier behind the column selector
    always_ff @(posedge core_clk) begin
        sense_bit <= cells_w[sense_sel]; // RQ1
    end

endmodule // pnvm_array

//--- logic/pnvm_top.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`include "pnvm_map.svh"

// Function
// RQ1: 128 bits stored as 16 rows of 8, one shared sense amplifier.
// RQ2: Select register at index 0E feeds row and column decoders.
// RQ3: Select bits 6..3 pick the row, bits 2..0 the column.
// RQ4: Select bit 7 is plain storage; reset clears the select register.
// RQ5: Status/control at index 0F; bit 1 always reads zero.
// RQ6: Reset clears controls, sets column-zero flag, data shows array bit 0.
// RQ7: Column-zero flag is one exactly when column 0 is selected.
// RQ8: Pump clock select one picks bus clock, zero ring oscillator; reset clears.
// RQ9: Software keeps ring oscillator when bus clock is below 1 MHz.
// RQ10: Pump runs on enable plus an operation, until operations all clear; the code also stops a starting pump when enable drops.
// RQ11: Data bit is undefined while pump enable is set.
// RQ12: Row erase with pump running zeroes the selected row.
// RQ13: Row erase together with full erase performs full erase.
// RQ14: Software sets at most one of program, row erase, full erase.
// RQ15: Program with pump running writes one to the selected bit.
// RQ16: Reset clears program and row erase.
// RQ17: Full erase zeroes the whole array; reset clears it.
// RQ18: Data bit follows sense amplifier; valid only with all controls zero.
// RQ19: Software programs: select, set program and enable, wait, clear both.
// RQ20: Software clears program before changing the select address.
// RQ21: Status/control field positions are named constants.
// RQ22: Startup and program pulse are cycle counts; no write before startup.
module pnvm_top #(
    parameter logic [`PNVM_CNT_W-1:0] PUMP_START_CYC = `PNVM_CNT_W'(`PNVM_PUMP_STARTUP_CYC),
    parameter logic [`PNVM_CNT_W-1:0] PGM_PULSE_CYC  = `PNVM_CNT_W'(`PNVM_PGM_PULSE_CYC)
) (
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire pnvm_pkg::pnvm_trans_t htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic                       pump_running,
    output logic                       pump_clk_from_bus
);
    import pnvm_pkg::*;

    logic [7:0]              sel_ff;
    pnvm_ctrl_t              ctrl_ff;
    logic                    wr_pend_ff;
    logic [31:0]             wr_addr_ff;
    logic                    rd_wait_ff;
    logic [31:0]             rd_addr_ff;
    logic [31:0]             hrdata_ff;
    logic                    hreadyout_ff;
    logic                    hresp_ff;
    logic                    pump_clk_ff;
    logic [`PNVM_CNT_W-1:0]  pulse_cnt_ff;
    logic                    addr_ok;
    logic                    wr_sel_hit;
    logic                    wr_sc_hit;
    logic [7:0]              nxt_sel;
    logic                    op_any;
    pnvm_cmd_t               cmd;
    logic                    pump_ready;
    logic                    pump_run_w;
    logic                    sense_bit;
    logic                    nvm_we;
    logic                    col_zero;
    logic [7:0]              status_byte;
    logic [31:0]             read_word;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // ======================================================================
    // AHB-Lite slave phases
    // Transfer size is not checked; every access is taken as a word
    assign addr_ok    = hsel && hready && (htrans == TR_NONSEQ || htrans == TR_SEQ);
    assign wr_sel_hit = wr_pend_ff && (wr_addr_ff == `PNVM_ADDR_SELECT);
    assign wr_sc_hit  = wr_pend_ff && (wr_addr_ff == `PNVM_ADDR_STATUS);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h00000000;
            rd_wait_ff <= 1'b0;
            rd_addr_ff <= 32'h00000000;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            rd_wait_ff <= addr_ok && !hwrite;
            if (addr_ok && hwrite) begin
                wr_addr_ff <= haddr;
            end
            if (addr_ok && !hwrite) begin
                rd_addr_ff <= haddr;
            end
        end
    end

    // One wait state on reads lets the sense amplifier settle on a new select
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= !(addr_ok && !hwrite);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hrdata_ff <= 32'h00000000;
        end else if (rd_wait_ff) begin
            hrdata_ff <= read_word;
        end
    end

    // ======================================================================
    // Bit select register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sel_ff <= `PNVM_SEL_RST; // RQ4
        end else if (wr_sel_hit) begin
            sel_ff <= hwdata[7:0]; // RQ2
        end
    end

    assign nxt_sel = wr_sel_hit ? hwdata[7:0] : sel_ff;

    // ======================================================================
    // Status/control register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_ff <= `PNVM_CTRL_RST; // RQ16
        end else if (wr_sc_hit) begin
            ctrl_ff.pump_clock_select <= hwdata[`PNVM_SC_PCLK]; // RQ21
            ctrl_ff.pump_enable       <= hwdata[`PNVM_SC_PEN];
            ctrl_ff.row_erase         <= hwdata[`PNVM_SC_ROW];
            ctrl_ff.bit_program       <= hwdata[`PNVM_SC_PGM];
            ctrl_ff.full_erase        <= hwdata[`PNVM_SC_FULL];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pump_clk_ff <= 1'b0;
        end else begin
            pump_clk_ff <= ctrl_ff.pump_clock_select; // RQ8
        end
    end

    assign col_zero = (sel_ff[2:0] == 3'h0); // RQ7

    // Sense is passed through even while pumping; software must ignore it
    always_comb begin
        status_byte = 8'h00;
        status_byte[`PNVM_SC_DATA] = sense_bit; // RQ18 RQ11
        status_byte[`PNVM_SC_PCLK] = ctrl_ff.pump_clock_select;
        status_byte[`PNVM_SC_PEN]  = ctrl_ff.pump_enable;
        status_byte[`PNVM_SC_ROW]  = ctrl_ff.row_erase;
        status_byte[`PNVM_SC_PGM]  = ctrl_ff.bit_program;
        status_byte[`PNVM_SC_FULL] = ctrl_ff.full_erase;
        status_byte[1]             = 1'b0; // RQ5
        status_byte[`PNVM_SC_CZF]  = col_zero; // RQ6
    end

    always_comb begin
        if (rd_addr_ff == `PNVM_ADDR_SELECT) begin
            read_word = {24'h000000, sel_ff};
        end else if (rd_addr_ff == `PNVM_ADDR_STATUS) begin
            read_word = {24'h000000, status_byte};
        end else begin
            read_word = 32'h00000000;
        end
    end

    // ======================================================================
    // Operation decode and program/erase timing
    assign op_any = ctrl_ff.row_erase | ctrl_ff.bit_program | ctrl_ff.full_erase;

    // Fixed priority gives a defined outcome when software sets several
    always_comb begin
        if (ctrl_ff.full_erase) begin
            cmd = CMD_FULL; // RQ13 RQ14
        end else if (ctrl_ff.row_erase) begin
            cmd = CMD_ROW;
        end else if (ctrl_ff.bit_program) begin
            cmd = CMD_PROG;
        end else begin
            cmd = CMD_NONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pulse_cnt_ff <= '0;
        end else if (!(pump_ready && op_any)) begin
            pulse_cnt_ff <= '0;
        end else if (pulse_cnt_ff != PGM_PULSE_CYC) begin
            pulse_cnt_ff <= pulse_cnt_ff + 16'd1;
        end
    end

    // Writes keep going while held, so a select change mid-pulse hits new bits
    assign nvm_we = pump_ready && op_any && (pulse_cnt_ff == PGM_PULSE_CYC); // RQ22

    pnvm_pump #(
        .START_CYC    (PUMP_START_CYC)
    ) u_pump (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .ctrl         (ctrl_ff),
        .pump_running (pump_run_w),
        .pump_ready   (pump_ready)
    );

    pnvm_array u_array (
        .core_clk     (core_clk),
        .sel          (sel_ff[6:0]),
        .sense_sel    (nxt_sel[6:0]),
        .cmd          (cmd),
        .wr_en        (nvm_we),
        .sense_bit    (sense_bit)
    );

    assign hrdata            = hrdata_ff;
    assign hreadyout         = hreadyout_ff;
    assign hresp             = hresp_ff;
    assign pump_running      = pump_run_w;
    assign pump_clk_from_bus = pump_clk_ff;

    // ======================================================================
    // Assertions
    a_sel_reset: assert property (disable iff (1'b0) !nrst |=> sel_ff == 8'h00) // RQ4
        else $error("select register not cleared by reset");

    a_ctrl_reset: assert property (disable iff (1'b0) !nrst |=> ctrl_ff == 5'h00) // RQ16
        else $error("control bits not cleared by reset");

    a_reset_czf: assert property (disable iff (1'b0) // RQ6
        !nrst ##1 (nrst && !wr_sel_hit) |-> col_zero)
        else $error("column zero flag not set after reset");

    a_czf_first_col: assert property (rd_wait_ff && rd_addr_ff == `PNVM_ADDR_STATUS // RQ7
        |=> hrdata_ff[`PNVM_SC_CZF] == ($past(sel_ff[2:0]) == 3'h0))
        else $error("column zero flag wrong on read");

    a_bit1_zero: assert property (rd_wait_ff && rd_addr_ff == `PNVM_ADDR_STATUS // RQ5
        |=> hrdata_ff[1] == 1'b0 && hrdata_ff[31:8] == 24'h000000)
        else $error("unimplemented status bits not zero");

    a_clk_select: assert property (wr_sc_hit // RQ8
        |=> ##1 pump_clk_from_bus == $past(hwdata[`PNVM_SC_PCLK], 2))
        else $error("pump clock select not following write");

    a_clk_reset: assert property (disable iff (1'b0) !nrst |=> !pump_clk_from_bus) // RQ8
        else $error("pump clock select not cleared by reset");

    a_pump_needs_req: assert property ($rose(pump_running) // RQ10
        |-> $past(ctrl_ff.pump_enable && op_any))
        else $error("pump started without enable and operation");

    a_pump_holds: assert property (pump_ready && op_any |=> pump_running) // RQ10
        else $error("running pump stopped while operation set");

    a_pump_stops: assert property (!op_any |=> !pump_running) // RQ10
        else $error("pump kept running with no operation set");

    a_startup_en: assert property (!pump_ready && !ctrl_ff.pump_enable |=> !pump_running) // RQ10
        else $error("pump starting without enable");

    a_write_after_start: assert property (nvm_we |-> $past(pump_ready)) // RQ22
        else $error("array written before pump startup done");

    a_full_wins: assert property (ctrl_ff.full_erase && ctrl_ff.row_erase // RQ13
        |-> cmd == CMD_FULL)
        else $error("row erase not overridden by full erase");

    a_prog_sets_bit: assert property ((nvm_we && cmd == CMD_PROG && !wr_sel_hit) // RQ15
        ##1 !wr_sel_hit |=> sense_bit)
        else $error("programmed bit not read back as one");

    a_row_clears_bit: assert property ((nvm_we && cmd == CMD_ROW && !wr_sel_hit) // RQ12
        ##1 !wr_sel_hit |=> !sense_bit)
        else $error("row erased bit not read back as zero");

    a_full_clears_bit: assert property ((nvm_we && cmd == CMD_FULL) // RQ17
        ##1 !wr_sel_hit |=> !sense_bit)
        else $error("full erase left a bit set");

    a_read_wait: assert property (addr_ok && !hwrite |=> !hreadyout ##1 hreadyout) // RQ18
        else $error("read wait state not exactly one cycle");

    c_program: cover property (nvm_we && cmd == CMD_PROG);
    c_row_erase: cover property (nvm_we && cmd == CMD_ROW);
    c_full_erase: cover property (nvm_we && cmd == CMD_FULL);
    c_status_read: cover property (rd_wait_ff && rd_addr_ff == `PNVM_ADDR_STATUS);

endmodule // pnvm_top

//--- sim/pnvm_top_tb.sv
`timescale 1ns/1ps
`include "pnvm_map.svh"

module pnvm_top_tb;
    import pnvm_pkg::*;

    // ======================================================================
    // Shortened counts keep each program or erase to a few cycles
    localparam logic [`PNVM_CNT_W-1:0] START_CYC = 16'h0004;
    localparam logic [`PNVM_CNT_W-1:0] PULSE_CYC = 16'h0003;
    localparam logic [31:0]            SEL_A     = `PNVM_ADDR_SELECT;
    localparam logic [31:0]            ST_A      = `PNVM_ADDR_STATUS;
    localparam logic [7:0]             M_FULL    = 8'h01 << `PNVM_SC_FULL;
    localparam logic [7:0]             M_PGM     = 8'h01 << `PNVM_SC_PGM;
    localparam logic [7:0]             M_ROW     = 8'h01 << `PNVM_SC_ROW;
    localparam logic [7:0]             M_PEN     = 8'h01 << `PNVM_SC_PEN;
    localparam logic [7:0]             M_PCLK    = 8'h01 << `PNVM_SC_PCLK;
    localparam logic [7:0]             M_CTL     = M_FULL | M_PGM | M_ROW | M_PEN | M_PCLK;

    logic        core_clk;
    logic        nrst;
    logic        hsel;
    logic [31:0] haddr;
    pnvm_trans_t htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pump_running;
    logic        pump_clk_from_bus;
    logic [127:0] mem_exp;
    logic [7:0]  sel_exp;
    logic [7:0]  q;
    int          fails;
    int          checks;

    pnvm_top #(.PUMP_START_CYC(START_CYC), .PGM_PULSE_CYC(PULSE_CYC)) pnvm_top_i (
        .core_clk          (core_clk),
        .nrst              (nrst),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hrdata            (hrdata),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .pump_running      (pump_running),
        .pump_clk_from_bus (pump_clk_from_bus)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ======================================================================
    // Checking helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m,
                        input string msg);
        checks++;
        if ((got & m) !== (exp & m)) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    function automatic logic [7:0] st_exp(input logic [7:0] ctl);
        logic [7:0] r;
        r = ctl & M_CTL;
        r[`PNVM_SC_CZF]  = (sel_exp[2:0] == 3'h0);
        r[`PNVM_SC_DATA] = mem_exp[sel_exp[6:0]];
        return r;
    endfunction

    // ======================================================================
    // Bus master; hready judged just before the edge, signals moved after it
    // Only the watchdog ends a wait that never sees ready
    task automatic wait_rdy(output logic [31:0] d);
        do begin
            @(negedge core_clk);
        end while (hreadyout !== 1'b1);
        d = hrdata;
        @(posedge core_clk);
    endtask

    task automatic xfer(input logic [31:0] a, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rq);
        logic [31:0] d;
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= TR_NONSEQ;
        wait_rdy(d);
        hsel   <= 1'b0;
        htrans <= TR_IDLE;
        hwdata <= {24'h000000, wd};
        wait_rdy(d);
        rq = d[7:0];
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        logic [7:0] dummy;
        xfer(a, 1'b1, v, dummy);
    endtask

    task automatic rd(input logic [31:0] a, output logic [7:0] v);
        xfer(a, 1'b0, 8'h00, v);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        sel_exp = 8'h00;
        @(posedge core_clk);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        rd(SEL_A, q);
        chk8(q, 8'h00, 8'hFF, "select after reset");
        rd(ST_A, q);
        chk8(q, st_exp(8'h00), 8'hFF, "status after reset");
        chk1(pump_running, 1'b0, "pump after reset");
        chk1(pump_clk_from_bus, 1'b0, "pump clock after reset");
        chk1(hresp, 1'b0, "response code");
        $display("test reset done");
    endtask

    task automatic t_select();
        logic [7:0] vals [7];
        vals = '{8'h01, 8'h07, 8'h08, 8'h7F, 8'h80, 8'hF8, 8'h00};
        foreach (vals[i]) begin
            wr(SEL_A, vals[i]);
            sel_exp = vals[i];
            rd(SEL_A, q);
            chk8(q, vals[i], 8'hFF, "select readback");
            rd(ST_A, q);
            chk8(q, st_exp(8'h00), 8'hFF, "column zero flag");
        end
        wr(32'h00000040, 8'hFF);
        rd(32'h00000040, q);
        chk8(q, 8'h00, 8'hFF, "unmapped read");
        rd(SEL_A, q);
        chk8(q, sel_exp, 8'hFF, "unmapped write leaks");
        wr(ST_A, M_PCLK | 8'h02);
        rd(ST_A, q);
        chk8(q, st_exp(M_PCLK), 8'hFF, "bit one and clock select");
        chk1(pump_clk_from_bus, 1'b1, "bus clock chosen");
        chk1(pump_running, 1'b0, "pump without operation");
        wr(ST_A, 8'h00);
        repeat (2) @(negedge core_clk);
        chk1(pump_clk_from_bus, 1'b0, "ring oscillator chosen");
        @(posedge core_clk);
        $display("test select done");
    endtask

    // Too short a request, enable alone, operation alone: nothing may be written
    task automatic t_short();
        wr(SEL_A, 8'h21);
        sel_exp = 8'h21;
        wr(ST_A, M_PGM | M_PEN);
        wr(ST_A, 8'h00);
        wr(ST_A, M_PEN);
        repeat (3) @(posedge core_clk);
        chk1(pump_running, 1'b0, "enable alone");
        wr(ST_A, M_PGM);
        repeat (START_CYC + PULSE_CYC + 3) @(posedge core_clk);
        chk1(pump_running, 1'b0, "operation alone");
        wr(ST_A, 8'h00);
        rd(ST_A, q);
        chk8(q, st_exp(8'h00), 8'hFF, "no write before startup");
        $display("test short done");
    endtask

    task automatic run_op(input logic [7:0] sel, input logic [7:0] ctl);
        wr(SEL_A, sel);
        sel_exp = sel;
        wr(ST_A, ctl | M_PEN);
        @(negedge core_clk);
        @(negedge core_clk);
        chk1(pump_running, 1'b1, "pump started");
        chk1(pump_clk_from_bus, ctl[`PNVM_SC_PCLK], "pump clock source");
        @(posedge core_clk);
        rd(ST_A, q);
        chk8(q, st_exp(ctl | M_PEN), 8'h7F, "controls while pumping");
        repeat (START_CYC + PULSE_CYC + 4) @(posedge core_clk);
        wr(ST_A, ctl);
        repeat (2) @(negedge core_clk);
        chk1(pump_running, 1'b1, "pump held by operation");
        @(posedge core_clk);
        wr(ST_A, 8'h00);
        @(negedge core_clk);
        @(negedge core_clk);
        chk1(pump_running, 1'b0, "pump stopped");
        @(posedge core_clk);
        if ((ctl & M_FULL) != 8'h00) mem_exp = '0;
        else if ((ctl & M_ROW) != 8'h00) mem_exp[{sel[6:3], 3'b000} +: 8] = 8'h00;
        else mem_exp[sel[6:0]] = 1'b1;
        $display("test operation %h at %h done", ctl, sel);
    endtask

    task automatic check_all();
        for (int i = 0; i < 128; i++) begin
            wr(SEL_A, 8'(i));
            sel_exp = 8'(i);
            rd(ST_A, q);
            chk8(q, st_exp(8'h00), 8'hFF, "array bit");
        end
        $display("test array sweep done");
    endtask

    // ======================================================================
    // Closing and watchdog
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        fails++;
        $display("unexpected at %0t: run took too long", $time);
        wrap_up();
    end

    initial begin
        nrst    = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h00000000;
        htrans  = TR_IDLE;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h00000000;
        mem_exp = '0;
        sel_exp = 8'h00;
        fails   = 0;
        checks  = 0;
        @(posedge core_clk);
        do_reset();
        t_reset();
        t_select();
        t_short();
        run_op(8'h00, M_PGM);
        run_op(8'h13, M_PGM | M_PCLK);
        run_op(8'h15, M_PGM);
        run_op(8'h7F, M_PGM);
        run_op(8'h31, M_PGM);
        check_all();
        run_op(8'h12, M_ROW);
        check_all();
        run_op(8'h38, M_ROW | M_FULL);
        check_all();
        run_op(8'h00, M_PGM);
        wr(ST_A, M_PGM | M_PEN);
        do_reset();
        t_reset();
        run_op(8'h40, M_FULL);
        check_all();
        wrap_up();
    end

endmodule // pnvm_top_tb
